//--- verilog/dual_timer_counter.sv
// Two 16-bit timer/counters with shared mode control and register port
//
// Operation
// - Timer 1 gated: counts only while run set and irq1 pin high.
// - Timer 1 counts internal clock, or count pin falling edges when selected.
// - Timer 0 gated: counts only while run set and irq0 pin high.
// - Timer 0 counts internal clock, or count pin falling edges when selected.
// - Timer 1 mode in mode control bits 5:4, Timer 0 in 1:0.
// - Mode 0: low byte is a 5-bit prescaler ahead of high byte.
// - Mode 1: low and high bytes form one 16-bit counter.
// - Mode 2: 8-bit low counter reloads from high byte.
// - Timer 0 mode 3: low byte is 8-bit counter on Timer 0 controls.
// - Timer 0 mode 3: high byte counts clocks under Timer 1 run.
// - Timer 1 in mode 3 is stopped and holds its count.
// - Timer 0 count readable and writable as low and high bytes.
// - Timer 1 count readable and writable as low and high bytes.
// - Overflow sets flag; service start clears it; software sets or clears it.
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_map.svh"

module dual_timer_counter
    import dual_timer_pkg::*;
#(
    parameter int prescale_bits = `PRESCALE_BITS
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire bus_req_type bus_req,
    output logic [7:0] read_data,
    input wire logic timer0_event_pin,
    input wire logic timer1_event_pin,
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic timer0_service_begin,
    input wire logic timer1_service_begin,
    output logic timer0_overflow_flag,
    output logic timer1_overflow_flag,
    output logic irq
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (prescale_bits < 1 || prescale_bits > 7)
    begin : g_bad_prescale
        $error("prescale_bits must lie between 1 and 7");
    end

    localparam logic [7:0] low_mask = 8'((9'h001 << prescale_bits) - 9'h001);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] timer_mode_control;
    logic [7:0] timer0_low_byte;
    logic [7:0] timer0_high_byte;
    logic [7:0] timer1_low_byte;
    logic [7:0] timer1_high_byte;
    logic timer0_run;
    logic timer1_run;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    // ----------------------------------------------------------------
    // One count step of a timer in a given mode
    // ----------------------------------------------------------------
    function automatic count_type step_count(input mode_type mode, input logic [7:0] low,
        input logic [7:0] high);
        count_type res;
        res.low = low;
        res.high = high;
        res.overflow = 1'h0;
        unique case (mode)
            mode_prescale:
            begin
                res.low = (low & ~low_mask) | ((low + 8'h01) & low_mask);
                if ((low & low_mask) == low_mask)
                begin
                    res.high = high + 8'h01;
                    res.overflow = (high == 8'hff);
                end
            end
            mode_sixteen:
            begin
                {res.high, res.low} = {high, low} + 16'h0001;
                res.overflow = ({high, low} == 16'hffff);
            end
            mode_reload:
            begin
                res.low = (low == 8'hff) ? high : low + 8'h01;
                res.overflow = (low == 8'hff);
            end
            mode_split:
            begin
                res.low = low + 8'h01;
                res.overflow = (low == 8'hff);
            end
        endcase
        return res;
    endfunction : step_count

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire logic write_control = bus_req.write && bus_req.addr == `OFS_TIMER_CONTROL;
    wire logic write_mode = bus_req.write && bus_req.addr == `OFS_TIMER_MODE_CONTROL;
    wire logic write_timer0_low = bus_req.write && bus_req.addr == `OFS_TIMER0_LOW_BYTE;
    wire logic write_timer0_high = bus_req.write && bus_req.addr == `OFS_TIMER0_HIGH_BYTE;
    wire logic write_timer1_low = bus_req.write && bus_req.addr == `OFS_TIMER1_LOW_BYTE;
    wire logic write_timer1_high = bus_req.write && bus_req.addr == `OFS_TIMER1_HIGH_BYTE;
    wire logic write_irq_status = bus_req.write && bus_req.addr == `OFS_IRQ_STATUS;
    wire logic write_irq_mask = bus_req.write && bus_req.addr == `OFS_IRQ_MASK;

    // ----------------------------------------------------------------
    // Mode control fields
    // ----------------------------------------------------------------
    // field positions
    wire mode_type timer1_mode = mode_type'(
        timer_mode_control[`BIT_TIMER1_MODE_SELECT_HIGH:`BIT_TIMER1_MODE_SELECT_LOW]);
    wire mode_type timer0_mode = mode_type'(
        timer_mode_control[`BIT_TIMER0_MODE_SELECT_HIGH:`BIT_TIMER0_MODE_SELECT_LOW]);
    wire logic timer1_gate = timer_mode_control[`BIT_TIMER1_GATE];
    wire logic timer0_gate = timer_mode_control[`BIT_TIMER0_GATE];
    wire logic timer1_counter = timer_mode_control[`BIT_TIMER1_COUNTER_SELECT];
    wire logic timer0_counter = timer_mode_control[`BIT_TIMER0_COUNTER_SELECT];
    wire logic timer0_split = (timer0_mode == mode_split);

    // ----------------------------------------------------------------
    // Count sources
    // ----------------------------------------------------------------
    logic timer0_fall;
    logic timer1_fall;

    fall_detect timer0_edge
    (
        .mclk(mclk),
        .reset(reset),
        .pin(timer0_event_pin),
        .fall(timer0_fall)
    );

    fall_detect timer1_edge
    (
        .mclk(mclk),
        .reset(reset),
        .pin(timer1_event_pin),
        .fall(timer1_fall)
    );

    wire logic timer0_enable = timer0_run && (!timer0_gate || ext_irq0_pin);
    wire logic timer1_enable = timer1_run && (!timer1_gate || ext_irq1_pin);
    wire logic timer0_tick = timer0_enable && (!timer0_counter || timer0_fall);
    // timer 1 source, stopped in mode 3
    wire logic timer1_tick = timer1_enable && (!timer1_counter || timer1_fall)
        && timer1_mode != mode_split;
    // split high byte on timer 1 run, internal clock only
    wire logic split_high_tick = timer0_split && timer1_run;

    // ----------------------------------------------------------------
    // Next counts and overflow events
    // ----------------------------------------------------------------
    wire count_type timer0_step = step_count(timer0_mode, timer0_low_byte, timer0_high_byte);
    wire count_type timer1_step = step_count(timer1_mode, timer1_low_byte, timer1_high_byte);

    wire logic timer0_overflow = timer0_tick && timer0_step.overflow;
    wire logic split_high_overflow = split_high_tick && timer0_high_byte == 8'hff;
    wire logic timer1_overflow = timer0_split ? split_high_overflow
        : timer1_tick && timer1_step.overflow;

    wire logic [7:0] next_timer0_low = write_timer0_low ? bus_req.wdata
        : timer0_tick ? timer0_step.low : timer0_low_byte;
    wire logic [7:0] next_timer0_high = write_timer0_high ? bus_req.wdata
        : timer0_split ? timer0_high_byte + 8'(split_high_tick)
        : timer0_tick ? timer0_step.high : timer0_high_byte;
    wire logic [7:0] next_timer1_low = write_timer1_low ? bus_req.wdata
        : timer1_tick ? timer1_step.low : timer1_low_byte;
    wire logic [7:0] next_timer1_high = write_timer1_high ? bus_req.wdata
        : timer1_tick ? timer1_step.high : timer1_high_byte;

    // ----------------------------------------------------------------
    // Flags and interrupt
    // ----------------------------------------------------------------
    // set wins over clear
    wire logic next_timer0_flag = timer0_overflow
        || (write_control ? bus_req.wdata[`BIT_TIMER0_OVERFLOW_FLAG]
        : timer0_overflow_flag && !timer0_service_begin);
    wire logic next_timer1_flag = timer1_overflow
        || (write_control ? bus_req.wdata[`BIT_TIMER1_OVERFLOW_FLAG]
        : timer1_overflow_flag && !timer1_service_begin);

    wire logic [1:0] irq_events = {timer1_overflow, timer0_overflow};
    wire logic [1:0] irq_clear = write_irq_status ? bus_req.wdata[1:0] : 2'h0;
    wire logic [1:0] next_irq_status = irq_events | (irq_status & ~irq_clear);
    wire logic [1:0] next_irq_mask = write_irq_mask ? bus_req.wdata[1:0] : irq_mask;

    // ----------------------------------------------------------------
    // Read selection
    // ----------------------------------------------------------------
    wire logic [7:0] control_view = {timer1_overflow_flag, timer1_run,
        timer0_overflow_flag, timer0_run, 4'h0};
    wire logic [7:0] read_select =
        bus_req.addr == `OFS_TIMER_CONTROL ? control_view
        : bus_req.addr == `OFS_TIMER_MODE_CONTROL ? timer_mode_control
        : bus_req.addr == `OFS_TIMER0_LOW_BYTE ? timer0_low_byte
        : bus_req.addr == `OFS_TIMER1_LOW_BYTE ? timer1_low_byte
        : bus_req.addr == `OFS_TIMER0_HIGH_BYTE ? timer0_high_byte
        : bus_req.addr == `OFS_TIMER1_HIGH_BYTE ? timer1_high_byte
        : bus_req.addr == `OFS_IRQ_STATUS ? {6'h00, irq_status}
        : bus_req.addr == `OFS_IRQ_MASK ? {6'h00, irq_mask}
        : 8'h00;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            timer_mode_control <= `RESET_BYTE;
            timer0_run <= 1'h0;
            timer1_run <= 1'h0;
        end
        else
        begin
            if (write_mode)
                timer_mode_control <= bus_req.wdata;
            if (write_control)
            begin
                timer0_run <= bus_req.wdata[`BIT_TIMER0_RUN];
                timer1_run <= bus_req.wdata[`BIT_TIMER1_RUN];
            end
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            timer0_low_byte <= `RESET_BYTE;
            timer0_high_byte <= `RESET_BYTE;
            timer1_low_byte <= `RESET_BYTE;
            timer1_high_byte <= `RESET_BYTE;
        end
        else
        begin
            timer0_low_byte <= next_timer0_low;
            timer0_high_byte <= next_timer0_high;
            timer1_low_byte <= next_timer1_low;
            timer1_high_byte <= next_timer1_high;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            timer0_overflow_flag <= 1'h0;
            timer1_overflow_flag <= 1'h0;
            irq_status <= `RESET_IRQ;
            irq_mask <= `RESET_IRQ;
            irq <= 1'h0;
            read_data <= `RESET_BYTE;
        end
        else
        begin
            timer0_overflow_flag <= next_timer0_flag;
            timer1_overflow_flag <= next_timer1_flag;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= |(next_irq_status & next_irq_mask);
            read_data <= bus_req.read ? read_select : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_gate_holds_timer0: assert property (
        timer0_gate && !ext_irq0_pin && !write_timer0_low |=> $stable(timer0_low_byte))
        else $error("timer 0 low byte moved while gated off");

    a_gate_holds_timer1: assert property (
        timer1_gate && !ext_irq1_pin && !write_timer1_low && !write_timer1_high
        |=> $stable({timer1_high_byte, timer1_low_byte}))
        else $error("timer 1 moved while gated off");

    a_clock_count_timer0: assert property (
        timer0_run && !timer0_gate && !timer0_counter && timer0_mode == mode_sixteen
        && !write_timer0_low && !write_timer0_high
        |=> {timer0_high_byte, timer0_low_byte}
        == $past({timer0_high_byte, timer0_low_byte}) + 16'h0001)
        else $error("timer 0 missed an internal clock");

    a_event_count_timer1: assert property (
        timer1_counter && !timer1_fall && !timer0_split
        && !write_timer1_low && !write_timer1_high
        |=> $stable({timer1_high_byte, timer1_low_byte}))
        else $error("timer 1 counted without a pin edge");

    a_prescale_wrap: assert property (
        timer0_tick && timer0_mode == mode_prescale && timer0_low_byte[4:0] == 5'h1f
        && prescale_bits == 5 && !write_timer0_low && !write_timer0_high
        |=> timer0_low_byte[4:0] == 5'h00
        && timer0_high_byte == $past(timer0_high_byte) + 8'h01)
        else $error("prescaler carry lost");

    a_reload_timer1: assert property (
        timer1_tick && timer1_mode == mode_reload && timer1_low_byte == 8'hff && !timer0_split
        && !write_timer1_low && !write_timer1_high
        |=> timer1_low_byte == timer1_high_byte && timer1_overflow_flag)
        else $error("timer 1 reload failed");

    a_mode3_stop: assert property (
        timer1_mode == mode_split && !write_timer1_low && !write_timer1_high
        ##1 timer1_mode == mode_split && !write_timer1_low && !write_timer1_high
        |=> $stable({timer1_high_byte, timer1_low_byte}))
        else $error("timer 1 counted in mode 3");

    a_split_high_count: assert property (
        timer0_split && timer1_run && !write_timer0_high
        |=> timer0_high_byte == $past(timer0_high_byte) + 8'h01)
        else $error("split high byte did not count");

    a_split_flag_route: assert property (
        split_high_overflow |=> timer1_overflow_flag && irq_status[`BIT_IRQ_TIMER1])
        else $error("split overflow did not set timer 1 flag");

    a_flag_set_wins: assert property (
        timer0_overflow && timer0_service_begin |=> timer0_overflow_flag)
        else $error("overflow lost against service clear");

    a_read_latency: assert property (
        bus_req.read && bus_req.addr == `OFS_TIMER0_LOW_BYTE
        |=> read_data == $past(timer0_low_byte)
        ##1 ($past(bus_req.read) || read_data == 8'h00))
        else $error("read data wrong");

    c_timer0_overflow: cover property (timer0_overflow);
    c_split_overflow: cover property (split_high_overflow);
    c_gated_hold: cover property (timer1_gate && timer1_run && !ext_irq1_pin);
    c_irq_raised: cover property (!irq ##1 irq);

endmodule : dual_timer_counter

`default_nettype wire

//--- verilog/dual_timer_map.svh
// Register offsets, field positions and reset values of the dual timer block
`ifndef DUAL_TIMER_MAP_SVH
`define DUAL_TIMER_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_TIMER_CONTROL 8'h88
`define OFS_TIMER_MODE_CONTROL 8'h89
`define OFS_TIMER0_LOW_BYTE 8'h8a
`define OFS_TIMER1_LOW_BYTE 8'h8b
`define OFS_TIMER0_HIGH_BYTE 8'h8c
`define OFS_TIMER1_HIGH_BYTE 8'h8d
`define OFS_IRQ_STATUS 8'hf0
`define OFS_IRQ_MASK 8'hf1

// ----------------------------------------------------------------
// Mode control fields
// ----------------------------------------------------------------
`define BIT_TIMER1_GATE 7
`define BIT_TIMER1_COUNTER_SELECT 6
`define BIT_TIMER1_MODE_SELECT_HIGH 5
`define BIT_TIMER1_MODE_SELECT_LOW 4
`define BIT_TIMER0_GATE 3
`define BIT_TIMER0_COUNTER_SELECT 2
`define BIT_TIMER0_MODE_SELECT_HIGH 1
`define BIT_TIMER0_MODE_SELECT_LOW 0

// ----------------------------------------------------------------
// Run and overflow fields, interrupt bits
// ----------------------------------------------------------------
`define BIT_TIMER0_RUN 4
`define BIT_TIMER0_OVERFLOW_FLAG 5
`define BIT_TIMER1_RUN 6
`define BIT_TIMER1_OVERFLOW_FLAG 7
`define BIT_IRQ_TIMER0 0
`define BIT_IRQ_TIMER1 1

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define RESET_BYTE 8'h00
`define RESET_IRQ 2'h0
`define PRESCALE_BITS 5

`endif

//--- verilog/dual_timer_pkg.sv
// Types shared by the dual timer block
package dual_timer_pkg;

    // ----------------------------------------------------------------
    // Counting modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        mode_prescale = 2'h0,
        mode_sixteen = 2'h1,
        mode_reload = 2'h2,
        mode_split = 2'h3
    } mode_type;

    // ----------------------------------------------------------------
    // Register bus request and count step result
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } bus_req_type;

    typedef struct packed
    {
        logic [7:0] high;
        logic [7:0] low;
        logic overflow;
    } count_type;

endpackage : dual_timer_pkg

//--- verilog/fall_detect.sv
// Count pin synchroniser with falling edge detector
`timescale 1ns/1ps
`default_nettype none

module fall_detect
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic pin,
    output logic fall
);

    logic sync_first;
    logic sync_second;
    logic sync_prev;

    // ----------------------------------------------------------------
    // Two stage synchroniser, then one stage of history
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            sync_first <= 1'h1;
            sync_second <= 1'h1;
            sync_prev <= 1'h1;
        end
        else
        begin
            sync_first <= pin;
            sync_second <= sync_first;
            sync_prev <= sync_second;
        end
    end

    assign fall = sync_prev & ~sync_second;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_fall_after_pin: assert property (
        !$past(reset, 3) && $past(pin, 3) && !$past(pin, 2) |-> fall)
        else $error("pin fall not seen three cycles later");

endmodule : fall_detect

`default_nettype wire

//--- sim/count_pin_model.sv
// Behavioural model of the external count and gate pins
`timescale 1ns/1ps
`default_nettype none

module count_pin_model
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic fall0,
    input wire logic fall1,
    input wire logic gate0,
    input wire logic gate1,
    output logic timer0_event_pin,
    output logic timer1_event_pin,
    output logic ext_irq0_pin,
    output logic ext_irq1_pin
);
    logic [1:0] low0;
    logic [1:0] low1;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            low0 <= 2'h0;
            low1 <= 2'h0;
        end
        else
        begin
            low0 <= fall0 ? 2'h3 : ((low0 != 2'h0) ? low0 - 2'h1 : 2'h0);
            low1 <= fall1 ? 2'h3 : ((low1 != 2'h0) ? low1 - 2'h1 : 2'h0);
        end
    end

    // Idle level of count pins is high
    assign timer0_event_pin = (low0 == 2'h0);
    assign timer1_event_pin = (low1 == 2'h0);
    assign ext_irq0_pin = gate0;
    assign ext_irq1_pin = gate1;
endmodule : count_pin_model
`default_nettype wire

//--- sim/tb.sv
// Self-checking testbench of the dual timer block
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module tb
    import dual_timer_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    bus_req_type bus_req = '0;
    logic [7:0] read_data;
    logic fall0 = 1'b0, fall1 = 1'b0, gate0 = 1'b0, gate1 = 1'b0, svc0 = 1'b0, svc1 = 1'b0;
    wire t0_pin, t1_pin, irq0_pin, irq1_pin;
    logic flag0, flag1, irq, rd_pend = 1'h0, pin_pend = 1'h0;
    logic [7:0] exp_q[$], msk_q[$], pin_q[$], pmk_q[$], e, m, v;
    logic [7:0] regs[8] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hf0, 8'hf1};
    int error_cnt = 0, cmp_count = 0, cyc = 0;

    dual_timer_counter dual_timer_counter_inst (.mclk(mclk), .reset(reset), .bus_req(bus_req),
        .read_data(read_data), .timer0_event_pin(t0_pin), .timer1_event_pin(t1_pin),
        .ext_irq0_pin(irq0_pin), .ext_irq1_pin(irq1_pin), .timer0_service_begin(svc0),
        .timer1_service_begin(svc1), .timer0_overflow_flag(flag0),
        .timer1_overflow_flag(flag1), .irq(irq));
    count_pin_model count_pin_model_inst (.mclk(mclk), .reset(reset), .fall0(fall0),
        .fall1(fall1), .gate0(gate0), .gate1(gate1), .timer0_event_pin(t0_pin),
        .timer1_event_pin(t1_pin), .ext_irq0_pin(irq0_pin), .ext_irq1_pin(irq1_pin));

    initial
    begin
        forever #12.5 mclk = ~mclk;
    end

    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= {a, d, 2'h2};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] k);
        exp_q.push_back(x);
        msk_q.push_back(k);
        bus_req <= {a, 8'h00, 2'h1};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
    endtask : rd

    // Notes expected {flag1, flag0, irq} under a mask for the monitor
    task chk_pins(input logic [2:0] x, input logic [2:0] k);
        pin_q.push_back({5'h00, x});
        pmk_q.push_back({5'h00, k});
        pin_pend <= 1'h1;
        @(posedge mclk);
        pin_pend <= 1'h0;
        @(posedge mclk);
    endtask : chk_pins

    task gate(input logic sel, input int n);
        if (sel)
            gate1 <= 1'b1;
        else
            gate0 <= 1'b1;
        repeat (n) @(posedge mclk);
        gate0 <= 1'b0;
        gate1 <= 1'b0;
        @(posedge mclk);
    endtask : gate

    task fall(input logic sel);
        fall0 <= ~sel;
        fall1 <= sel;
        @(posedge mclk);
        fall0 <= 1'b0;
        fall1 <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask : fall

    // ----------------------------------------------------------------
    // Read data monitor and timeout
    // ----------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (rd_pend)
        begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            `CHECK(read_data & m, e)
        end
        if (pin_pend)
        begin
            e = pin_q.pop_front();
            m = pmk_q.pop_front();
            `CHECK({5'h00, flag1, flag0, irq} & m, e)
        end
        rd_pend <= bus_req.read;
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hd264f6c2));
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 8; i++) rd(regs[i], 8'h00, 8'hff);
        for (int i = 1; i < 6; i++)
        begin
            v = 8'($urandom);
            wr(regs[i], v);
            rd(regs[i], v, 8'hff);
        end
        wr(8'h90, v);
        rd(8'h90, 8'h00, 8'hff);
        // Mode 1 overflow, flag, service and interrupt
        wr(8'h89, 8'h01);
        wr(8'h8a, 8'hfe);
        wr(8'h8c, 8'hff);
        wr(8'h88, 8'h10);
        repeat (4) @(posedge mclk);
        chk_pins(3'h2, 3'h2);
        chk_pins(3'h0, 3'h1);
        wr(8'hf1, 8'h03);
        chk_pins(3'h1, 3'h1);
        svc0 <= 1'h1;
        @(posedge mclk);
        svc0 <= 1'h0;
        chk_pins(3'h0, 3'h2);
        wr(8'h88, 8'h00);
        rd(8'hf0, 8'h01, 8'h03);
        wr(8'hf0, 8'h01);
        chk_pins(3'h0, 3'h1);
        // Gated timers count only with pin high
        wr(8'h89, 8'h99);
        for (int i = 2; i < 6; i++) wr(regs[i], 8'h00);
        wr(8'h88, 8'h50);
        repeat (8) @(posedge mclk);
        gate(1'b0, 10);
        gate(1'b1, 7);
        rd(8'h8a, 8'h0a, 8'hff);
        rd(8'h8b, 8'h07, 8'hff);
        // Counter select, falling edges on count pins
        wr(8'h89, 8'h55);
        wr(8'h8a, 8'h00);
        wr(8'h8b, 8'h00);
        repeat (3) fall(1'b0);
        repeat (2) fall(1'b1);
        rd(8'h8a, 8'h03, 8'hff);
        rd(8'h8b, 8'h02, 8'hff);
        // Mode 2 reload and mode 0 prescaler
        wr(8'h89, 8'h0a);
        wr(8'h8c, 8'hf0);
        wr(8'h8a, 8'hfe);
        wr(8'h88, 8'h10);
        gate(1'b0, 4);
        rd(8'h8a, 8'hf2, 8'hff);
        rd(8'h88, 8'h20, 8'h20);
        wr(8'h89, 8'h08);
        wr(8'h8a, 8'h1e);
        wr(8'h8c, 8'h00);
        gate(1'b0, 3);
        rd(8'h8a, 8'h01, 8'h1f);
        rd(8'h8c, 8'h01, 8'hff);
        // Split mode of Timer 0, Timer 1 stopped
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h3b);
        wr(8'h8c, 8'hfe);
        wr(8'h8a, 8'h00);
        wr(8'h8b, 8'h55);
        wr(8'h88, 8'h50);
        repeat (6) @(posedge mclk);
        chk_pins(3'h4, 3'h4);
        chk_pins(3'h0, 3'h2);
        svc1 <= 1'h1;
        @(posedge mclk);
        svc1 <= 1'h0;
        chk_pins(3'h0, 3'h4);
        rd(8'h8b, 8'h55, 8'hff);
        rd(8'h8a, 8'h00, 8'hff);
        gate(1'b0, 2);
        rd(8'h8a, 8'h02, 8'hff);
        rd(8'hf0, 8'h02, 8'h02);
        // Software sets both flags
        wr(8'h88, 8'ha0);
        chk_pins(3'h7, 3'h7);
        repeat (3) @(posedge mclk);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
